// File: dc_servo_encoder_pwm_core_test.sv
// Self-checking bench for the servo motor core
`timescale 1ns/10ps
module dc_servo_encoder_pwm_core_test;
	localparam int DIV   = 1;
	localparam int EVT   = 9 * 1024 * DIV;
	localparam int LIMIT = 60000;
	logic                        core_clk;
	logic                        reset;
	dsc_pkg::dsc_av_req_t        req;
	logic [31:0]                 rdata;
	logic                        wreq;
	logic                        up_pulse;
	logic                        down_pulse;
	logic                        index_input;
	logic [dsc_pkg::LIMIT_N-1:0] limit_inputs;
	logic                        tick_in;
	logic                        pwm;
	logic                        amp_en;
	logic                        srv_req;
	int                          failures;
	int                          total_checks;
	int                          cycle_count;
	logic [31:0]                 got;
	logic [31:0]                 highs;
	logic [3:0]                  lv;
	logic [9:0]                  duty_tab [3] = '{10'h200, 10'h3FF, 10'h000};
	time                         t_first;

	dsc_core #(.PWM_DIV(DIV)) dut (
		.core_clk         (core_clk),
		.reset            (reset),
		.avs_req          (req),
		.avs_readdata     (rdata),
		.avs_waitrequest  (wreq),
		.up_pulse         (up_pulse),
		.down_pulse       (down_pulse),
		.index_input      (index_input),
		.limit_inputs     (limit_inputs),
		.tick_clock_input (tick_in),
		.motor_drive_pwm  (pwm),
		.amplifier_enable (amp_en),
		.servo_request    (srv_req)
	);

	dsc_far_side far (
		.core_clk         (core_clk),
		.motor_drive_pwm  (pwm),
		.amplifier_enable (amp_en),
		.up_pulse         (up_pulse),
		.down_pulse       (down_pulse),
		.tick_clock_input (tick_in),
		.bridge_fwd       (),
		.bridge_rev       ()
	);

	// ********
	// Clock and watchdog
	// ********
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycle_count++;
		if (cycle_count == LIMIT) begin
			failures++;
			$display("unexpected at %0t: run timed out", $time);
			complete_run();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: word %h, want %h", $time, g, e);
		end
	endtask : check_word

	task automatic check_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: level %b, want %b", $time, g, e);
		end
	endtask : check_bit

	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		req <= '{address: a, read: !wr, write: wr, writedata: d};
		@(negedge core_clk);
		while (wreq !== 1'b0) @(negedge core_clk);
		@(posedge core_clk);
		got = rdata;
		req <= '0;
	endtask : bus

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check_word(got, e);
	endtask : rd

	task automatic wait_event;
		@(negedge core_clk);
		while (srv_req !== 1'b1) @(negedge core_clk);
	endtask : wait_event

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	// ********
	// Tests
	// ********
	initial begin
		reset = 1'b1;
		req = '0;
		index_input = 1'b0;
		limit_inputs = '0;
		failures = 0;
		total_checks = 0;
		cycle_count = 0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		check_bit(amp_en, 1'b0);
		check_bit(srv_req, 1'b0);
		rd(dsc_pkg::OFS_CTRL, 32'h0000_0000);
		rd(dsc_pkg::OFS_DUTY, 32'h0000_0200);
		rd(dsc_pkg::OFS_PERIOD, 32'h0000_0008);
		rd(dsc_pkg::OFS_UP, 32'h0000_0000);
		rd(6'h24, 32'h0000_0000);
		$display("test reset done");

		// Read-only counter must ignore the write
		far.steps(1'b1, 12);
		far.steps(1'b0, 5);
		bus(1'b1, dsc_pkg::OFS_UP, 32'hFFFF_FFFF);
		rd(dsc_pkg::OFS_UP, 32'h0000_000C);
		rd(dsc_pkg::OFS_DOWN, 32'h0000_0005);
		wait_event();
		t_first = $time;
		rd(dsc_pkg::OFS_TICK, 32'h0000_0000);
		rd(dsc_pkg::OFS_VEL, 32'h0000_0007);
		rd(dsc_pkg::OFS_POS, 32'h0000_0700);
		bus(1'b1, dsc_pkg::OFS_STATUS, 32'h0000_0001);
		@(negedge core_clk);
		check_bit(srv_req, 1'b0);
		$display("test first event done");

		far.steps(1'b0, 10);
		rd(dsc_pkg::OFS_DOWN, 32'h0000_000F);
		wait_event();
		check_word(32'(($time - t_first) / 8), 32'(EVT));
		rd(dsc_pkg::OFS_VEL, 32'hFFFF_FFF6);
		rd(dsc_pkg::OFS_POS, 32'hFFFF_FD00);
		$display("test second event done");

		bus(1'b1, dsc_pkg::OFS_CTRL, 32'h0000_0001);
		@(negedge core_clk);
		check_bit(amp_en, 1'b1);
		rd(dsc_pkg::OFS_CTRL, 32'h0000_0001);
		// Mid-run reset with request pending and amplifier on
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		check_bit(amp_en, 1'b0);
		check_bit(srv_req, 1'b0);
		rd(dsc_pkg::OFS_UP, 32'h0000_0000);
		rd(dsc_pkg::OFS_DUTY, 32'h0000_0200);
		$display("test enable and reset done");

		for (int i = 0; i < 2; i++) begin
			lv = (i == 0) ? 4'b1101 : 4'b0010;
			{index_input, limit_inputs} <= lv;
			repeat (4) @(negedge core_clk);
			bus(1'b0, dsc_pkg::OFS_STATUS, 32'h0000_0000);
			check_word(got & 32'h0000_001E, {27'h0, lv, 1'b0});
		end
		$display("test sense inputs done");

		bus(1'b1, dsc_pkg::OFS_PERIOD, 32'h0000_0002);
		rd(dsc_pkg::OFS_PERIOD, 32'h0000_0002);
		wait_event();
		t_first = $time;
		bus(1'b1, dsc_pkg::OFS_STATUS, 32'h0000_0001);
		wait_event();
		check_word(32'(($time - t_first) / 8), 32'(3 * 1024 * DIV));
		$display("test period done");

		// Any full-period window holds exactly the duty count of highs
		foreach (duty_tab[i]) begin
			bus(1'b1, dsc_pkg::OFS_DUTY, {22'h0, duty_tab[i]});
			repeat (2100 * DIV) @(negedge core_clk);
			highs = 32'h0000_0000;
			repeat (1024 * DIV) begin
				@(negedge core_clk);
				highs = highs + 32'(pwm);
			end
			check_word(highs, 32'(duty_tab[i]) * DIV);
		end
		$display("test duty done");
		complete_run();
	end
endmodule : dc_servo_encoder_pwm_core_test

// File: dsc_core.sv
// Servo motor core: encoder counters, PWM drive, servo tick and registers
`timescale 1ns/10ps
module dsc_core #(
	parameter int PWM_DIV = dsc_pkg::PWM_DIV
) (
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	input  wire dsc_pkg::dsc_av_req_t          avs_req,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic                          up_pulse,
	input  wire logic                          down_pulse,
	input  wire logic                          index_input,
	input  wire logic [dsc_pkg::LIMIT_N-1:0]   limit_inputs,
	input  wire logic                          tick_clock_input,
	output logic                               motor_drive_pwm,
	output logic                               amplifier_enable,
	output logic                               servo_request
);
	localparam int NSYNC = 4 + dsc_pkg::LIMIT_N;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [NSYNC-1:0] in_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic [2:0]       edge_prev_reg;
	logic             up_step;
	logic             down_step;
	logic             tick_step;

	assign in_raw = {limit_inputs, index_input, tick_clock_input,
		down_pulse, up_pulse};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= in_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// Rising edges of up, down and tick; relies on decoding outside
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			edge_prev_reg <= 3'h0;
		end else begin
			edge_prev_reg <= sync2_reg[2:0];
		end
	end

	assign up_step   = sync2_reg[0] & ~edge_prev_reg[0];
	assign down_step = sync2_reg[1] & ~edge_prev_reg[1];
	assign tick_step = sync2_reg[2] & ~edge_prev_reg[2];

	// ****************************************************************
	// Encoder counters
	// ****************************************************************
	logic [dsc_pkg::CNT_W-1:0] up_count_counter_reg;
	logic [dsc_pkg::CNT_W-1:0] down_count_counter_reg;

	// Free running, wrap silently; never cleared by software
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			up_count_counter_reg   <= '0;
			down_count_counter_reg <= '0;
		end else begin
			if (up_step) begin
				up_count_counter_reg <= up_count_counter_reg + 1'b1;
			end
			if (down_step) begin
				down_count_counter_reg <= down_count_counter_reg + 1'b1;
			end
		end
	end

	// ****************************************************************
	// PWM time base and output
	// ****************************************************************
	logic [7:0]                 pwm_div_reg;
	logic [dsc_pkg::DUTY_W-1:0] pwm_time_base_reg;
	logic [dsc_pkg::DUTY_W-1:0] duty_reg;
	logic [dsc_pkg::DUTY_W-1:0] duty_active_reg;
	logic                       pwm_step;
	logic                       pwm_wrap;

	assign pwm_step = pwm_div_reg == 8'(PWM_DIV - 1);
	assign pwm_wrap = pwm_step & (&pwm_time_base_reg);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pwm_div_reg       <= 8'h00;
			pwm_time_base_reg <= '0;
		end else begin
			pwm_div_reg <= pwm_step ? 8'h00 : pwm_div_reg + 8'h01;
			if (pwm_step) begin
				pwm_time_base_reg <= pwm_time_base_reg + 1'b1;
			end
		end
	end

	// Duty only loaded at period end so no runt pulse reaches the bridge
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			duty_active_reg <= dsc_pkg::DUTY_RESET;
			motor_drive_pwm <= 1'b0;
		end else begin
			if (pwm_wrap) begin
				duty_active_reg <= duty_reg;
			end
			motor_drive_pwm <= pwm_time_base_reg < duty_active_reg;
		end
	end

	// ****************************************************************
	// Servo tick and position tracking
	// ****************************************************************
	logic [dsc_pkg::PER_W-1:0] servo_tick_counter_reg;
	logic [dsc_pkg::PER_W-1:0] servo_period_value_reg;
	logic                      servo_event;
	logic [dsc_pkg::CNT_W-1:0] up_prev_reg;
	logic [dsc_pkg::CNT_W-1:0] down_prev_reg;
	logic [dsc_pkg::CNT_W-1:0] velocity_reg;
	logic [dsc_pkg::CNT_W-1:0] velocity_next;
	logic [dsc_pkg::POS_W-1:0] position_reg;

	assign servo_event = tick_step
		& (servo_tick_counter_reg == servo_period_value_reg);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			servo_tick_counter_reg <= '0;
		end else if (servo_event) begin
			servo_tick_counter_reg <= '0;
		end else if (tick_step) begin
			servo_tick_counter_reg <= servo_tick_counter_reg + 1'b1;
		end
	end

	// Wrap-safe while fewer than 32768 counts pass per period
	assign velocity_next = (up_count_counter_reg - up_prev_reg)
		- (down_count_counter_reg - down_prev_reg);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			up_prev_reg   <= '0;
			down_prev_reg <= '0;
			velocity_reg  <= '0;
			position_reg  <= '0;
		end else if (servo_event) begin
			up_prev_reg   <= up_count_counter_reg;
			down_prev_reg <= down_count_counter_reg;
			velocity_reg  <= velocity_next;
			position_reg  <= position_reg + {{(dsc_pkg::POS_W
				- dsc_pkg::CNT_W - dsc_pkg::FRAC_W){velocity_next[
				dsc_pkg::CNT_W-1]}}, velocity_next,
				dsc_pkg::FRAC_W'(0)};
		end
	end

	// ****************************************************************
	// Register bus slave
	// ****************************************************************
	dsc_pkg::dsc_sense_t sense;
	logic                req;
	logic                ack_reg;
	logic                wr_done;
	logic [31:0]         rd_next;

	assign sense = '{index_level: sync2_reg[3],
		limit_level: sync2_reg[NSYNC-1:4]};
	assign req             = avs_req.read | avs_req.write;
	assign avs_waitrequest = req & ~ack_reg;
	assign wr_done         = avs_req.write & ack_reg;

	// One wait state: read data is latched while waitrequest is high
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		case (avs_req.address)
			dsc_pkg::OFS_CTRL: rd_next[dsc_pkg::CTRL_AMP_EN_BIT] =
				amplifier_enable;
			dsc_pkg::OFS_DUTY: rd_next[dsc_pkg::DUTY_W-1:0] = duty_reg;
			dsc_pkg::OFS_PERIOD: rd_next[dsc_pkg::PER_W-1:0] =
				servo_period_value_reg;
			dsc_pkg::OFS_STATUS: begin
				rd_next[dsc_pkg::STAT_PEND_BIT] = servo_request;
				rd_next[dsc_pkg::STAT_LIMIT_LSB +: dsc_pkg::LIMIT_N] =
					sense.limit_level;
				rd_next[dsc_pkg::STAT_INDEX_BIT] = sense.index_level;
			end
			dsc_pkg::OFS_UP: rd_next[dsc_pkg::CNT_W-1:0] =
				up_count_counter_reg;
			dsc_pkg::OFS_DOWN: rd_next[dsc_pkg::CNT_W-1:0] =
				down_count_counter_reg;
			dsc_pkg::OFS_VEL: rd_next = {{(32 - dsc_pkg::CNT_W){
				velocity_reg[dsc_pkg::CNT_W-1]}}, velocity_reg};
			dsc_pkg::OFS_POS: rd_next = position_reg;
			dsc_pkg::OFS_TICK: rd_next[dsc_pkg::PER_W-1:0] =
				servo_tick_counter_reg;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_req.read & ~ack_reg) begin
			avs_readdata <= rd_next;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			amplifier_enable       <= 1'b0;
			duty_reg               <= dsc_pkg::DUTY_RESET;
			servo_period_value_reg <= dsc_pkg::PERIOD_RESET;
		end else if (wr_done) begin
			case (avs_req.address)
				dsc_pkg::OFS_CTRL: amplifier_enable <=
					avs_req.writedata[dsc_pkg::CTRL_AMP_EN_BIT];
				dsc_pkg::OFS_DUTY: duty_reg <=
					avs_req.writedata[dsc_pkg::DUTY_W-1:0];
				dsc_pkg::OFS_PERIOD: servo_period_value_reg <=
					avs_req.writedata[dsc_pkg::PER_W-1:0];
				default: ;
			endcase
		end
	end

	// Pending flag: a new servo event wins over a software clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			servo_request <= 1'b0;
		end else if (servo_event) begin
			servo_request <= 1'b1;
		end else if (wr_done && avs_req.address == dsc_pkg::OFS_STATUS
			&& avs_req.writedata[dsc_pkg::STAT_PEND_BIT]) begin
			servo_request <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_tick_at_period;
		tick_step && servo_tick_counter_reg == servo_period_value_reg;
	endsequence

	sequence s_tick_below;
		tick_step && servo_tick_counter_reg != servo_period_value_reg;
	endsequence

	a_tick_wraps_zero: assert property (s_tick_at_period |=>
		servo_tick_counter_reg == '0 && servo_request)
		else $error("Tick counter did not wrap with request");

	a_tick_counts_up: assert property (s_tick_below |=>
		servo_tick_counter_reg == $past(servo_tick_counter_reg) + 1'b1)
		else $error("Tick counter did not advance");

	a_tick_holds: assert property (!tick_step |=>
		$stable(servo_tick_counter_reg))
		else $error("Tick counter moved without tick edge");

	a_up_counts: assert property ($rose(sync2_reg[0]) |=>
		up_count_counter_reg == $past(up_count_counter_reg) + 1'b1)
		else $error("Up counter missed a pulse");

	a_down_counts: assert property ($rose(sync2_reg[1]) |=>
		down_count_counter_reg == $past(down_count_counter_reg) + 1'b1)
		else $error("Down counter missed a pulse");

	a_duty_boundary: assert property (!pwm_wrap |=>
		$stable(duty_active_reg))
		else $error("Duty changed inside a PWM period");

	a_pwm_level: assert property (!reset |=> motor_drive_pwm ==
		($past(pwm_time_base_reg) < $past(duty_active_reg)))
		else $error("PWM level does not follow duty");

	a_velocity_calc: assert property (servo_event |=>
		velocity_reg == $past(velocity_next) && up_prev_reg ==
		$past(up_count_counter_reg))
		else $error("Velocity not captured on servo event");

	a_position_sum: assert property (servo_event |=>
		position_reg[dsc_pkg::POS_W-1:dsc_pkg::FRAC_W] ==
		$past(position_reg[dsc_pkg::POS_W-1:dsc_pkg::FRAC_W])
		+ {{(dsc_pkg::POS_W - dsc_pkg::CNT_W - dsc_pkg::FRAC_W){
		$past(velocity_next[dsc_pkg::CNT_W-1])}}, $past(velocity_next)}
		&& position_reg[dsc_pkg::FRAC_W-1:0] ==
		$past(position_reg[dsc_pkg::FRAC_W-1:0]))
		else $error("Position did not add velocity");

	a_duty_load: assert property (pwm_wrap |=>
		duty_active_reg == $past(duty_reg))
		else $error("Duty not loaded at period end");

	a_pend_clear: assert property (wr_done && !servo_event &&
		avs_req.address == dsc_pkg::OFS_STATUS && avs_req.writedata[
		dsc_pkg::STAT_PEND_BIT] |=> !servo_request)
		else $error("Pending request not cleared");

	a_up_holds: assert property (!up_step |=>
		$stable(up_count_counter_reg))
		else $error("Up counter moved without a pulse");

	a_down_holds: assert property (!down_step |=>
		$stable(down_count_counter_reg))
		else $error("Down counter moved without a pulse");

	a_request_sticky: assert property (servo_request && !wr_done |=>
		servo_request)
		else $error("Pending request dropped without clear");

	a_amp_write: assert property (wr_done &&
		avs_req.address == dsc_pkg::OFS_CTRL |=> amplifier_enable ==
		$past(avs_req.writedata[dsc_pkg::CTRL_AMP_EN_BIT]))
		else $error("Amplifier enable not written");

	a_bus_one_wait: assert property (req && !ack_reg |=>
		!avs_waitrequest || !req)
		else $error("Bus answer took more than one wait state");
endmodule : dsc_core

// File: dsc_far_side.sv
// Far-side model: encoder decoder pulses and bridge amplifier
`timescale 1ns/10ps
module dsc_far_side (
	input  wire logic core_clk,
	input  wire logic motor_drive_pwm,
	input  wire logic amplifier_enable,
	output logic      up_pulse,
	output logic      down_pulse,
	output logic      tick_clock_input,
	output logic      bridge_fwd,
	output logic      bridge_rev
);
	// ********
	// Amplifier
	// ********
	assign tick_clock_input = motor_drive_pwm;
	// Disabled bridge modelled as both halves off
	assign bridge_fwd = amplifier_enable & motor_drive_pwm;
	assign bridge_rev = amplifier_enable & ~motor_drive_pwm;

	// ********
	// Decoder
	// ********
	initial begin
		up_pulse   = 1'b0;
		down_pulse = 1'b0;
	end

	// Three clocks high and four low between steps keeps each step clear of the synchroniser
	// Callers keep n far below 32767 per servo period
	task automatic steps(input logic dir_up, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			up_pulse   <= dir_up;
			down_pulse <= !dir_up;
			repeat (3) @(posedge core_clk);
			up_pulse   <= 1'b0;
			down_pulse <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask : steps
endmodule : dsc_far_side

// File: dsc_pkg.sv
// Constants, register map and carrier types of the servo motor core
package dsc_pkg;
	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W  = 6;
	localparam int CNT_W   = 16;
	localparam int DUTY_W  = 10;
	localparam int PER_W   = 8;
	localparam int POS_W   = 32;
	localparam int FRAC_W  = 8;
	localparam int LIMIT_N = 3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam longint CLK_HZ   = 125000000;
	localparam longint PWM_HZ   = 32200;
	localparam longint PWM_STEP = 1024;
	// Nearest whole divider; 125 MHz cannot give exactly 32.2 kHz
	localparam int PWM_DIV = int'((CLK_HZ + (PWM_HZ * PWM_STEP) / 2)
		/ (PWM_HZ * PWM_STEP));

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_DUTY   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_UP     = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_DOWN   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_VEL    = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_POS    = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_TICK   = 6'h20;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_AMP_EN_BIT = 0;
	localparam int STAT_PEND_BIT   = 0;
	localparam int STAT_LIMIT_LSB  = 1;
	localparam int STAT_INDEX_BIT  = 4;
	localparam logic [DUTY_W-1:0] DUTY_RESET   = 10'h200;
	localparam logic [PER_W-1:0]  PERIOD_RESET = 8'h08;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
	} dsc_av_req_t;

	typedef struct packed {
		logic               index_level;
		logic [LIMIT_N-1:0] limit_level;
	} dsc_sense_t;
endpackage : dsc_pkg
